//--- sfm_dev.sv
// FIFO port of the interface device, seen from the external master
//
// What this block does
// - Master sets select 25 ns before edge
// - Output enable only gates the data bus
// - Read valid only with select and strobe
// - Sync read edge advances pointer, shows next
// - Burst read keeps strobe and enable asserted
// - Write valid only with select and strobe
// - Sync write edge stores word, updates flags
// - Burst write holds strobe, new word each edge
// - Packet end commits words, last included
// - Select held steady during packet end
// - Auto mode commits at configured length
// - Short packet end one cycle after auto
// - Select change updates flags and data
// - Async write stores on strobe release
// - Async read drives word, then advances
// - Async packet end never with write strobe
`timescale 1ns/1ps
module sfm_dev #(
	parameter int DATA_W   = sfm_pkg::DATA_W,
	parameter int SEL_W    = sfm_pkg::SEL_W,
	parameter int NUM_FIFO = sfm_pkg::NUM_FIFO,
	parameter int DEPTH    = sfm_pkg::FIFO_DEPTH,
	parameter int LEN_W    = sfm_pkg::LEN_W
) (
	input  wire logic              sys_clk_i,
	input  wire logic              rst_i,
	input  wire logic              clk_en_i,
	input  wire logic              async_mode_i,
	input  wire logic              auto_mode_i,
	input  wire logic [LEN_W-1:0]  auto_commit_length_i,
	input  wire logic [SEL_W-1:0]  usr_fifo_i,
	input  wire logic              usr_push_i,
	input  wire logic [DATA_W-1:0] usr_data_i,
	output logic                   usr_ready_o,
	input  wire logic              usr_pop_i,
	output logic                   usr_rd_valid_o,
	output logic      [DATA_W-1:0] usr_rd_data_o,
	output logic                   commit_o,
	output logic      [SEL_W-1:0]  commit_fifo_o,
	output logic      [LEN_W-1:0]  commit_len_o,
	sfm_if.dev                     link
);
	localparam int AW    = $clog2(DEPTH);
	localparam int NSEL  = 1 << SEL_W;
	localparam int PIN_W = SEL_W + DATA_W + 6;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	function automatic logic sel_hit(input logic [SEL_W-1:0] sel,
		input int idx);
		sel_hit = (int'(sel) == idx);
	endfunction : sel_hit

	// =========================================================
	// Pin sampling
	logic [PIN_W-1:0]  pin_s;
	logic [PIN_W-1:0]  pin_d_reg;
	logic              p_clk;
	logic              p_cs;
	logic              p_rd;
	logic              p_wr;
	logic              p_oe;
	logic              p_pe;
	logic [SEL_W-1:0]  p_sel;
	logic [DATA_W-1:0] p_data;
	logic              d_clk;
	logic              d_cs;
	logic              d_rd;
	logic              d_wr;
	logic              d_oe;
	logic              d_pe;
	logic [SEL_W-1:0]  d_sel;
	logic [DATA_W-1:0] d_data;

	sfm_sync #(.WIDTH(PIN_W)) u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.clk_en_i  (clk_en_i),
		.async_i   ({link.interface_clock, link.fifo_chip_select,
			link.fifo_read_strobe, link.fifo_write_strobe,
			link.fifo_output_enable, link.packet_commit_strobe,
			link.fifo_select, link.data}),
		.sync_o    (pin_s)
	);

	// Previous sample: the pin levels just before a link edge
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_d_reg <= '0;
		end else if (clk_en_i) begin
			pin_d_reg <= pin_s;
		end
	end

	assign {p_clk, p_cs, p_rd, p_wr, p_oe, p_pe, p_sel, p_data} = pin_s;
	assign {d_clk, d_cs, d_rd, d_wr, d_oe, d_pe, d_sel, d_data} = pin_d_reg;

	// =========================================================
	// Transfer decode
	logic link_rise;
	logic take_rd;
	logic take_wr;
	logic take_pe;

	assign link_rise = p_clk & ~d_clk;

	always_comb begin
		if (async_mode_i) begin
			take_wr = d_cs & d_wr & ~p_wr;
			take_rd = d_cs & d_rd & ~p_rd;
			take_pe = p_pe & ~d_pe;
		end else begin
			take_wr = link_rise & d_cs & d_wr;
			take_rd = link_rise & d_cs & d_rd;
			take_pe = link_rise & d_pe;
		end
	end

	// =========================================================
	// FIFO storage; unused select codes read as empty and full
	logic [NSEL-1:0]             empty_w;
	logic [NSEL-1:0]             full_w;
	logic [NSEL-1:0][DATA_W-1:0] head_w;
	logic [NSEL-1:0][LEN_W-1:0]  ucnt_w;
	logic                        commit_fire;

	genvar g;
	generate
		for (g = 0; g < NSEL; g++) begin : g_fifo
			if (g < NUM_FIFO) begin : g_real
				logic [DATA_W-1:0] mem [DEPTH];
				logic [AW-1:0]     wp_reg;
				logic [AW-1:0]     rp_reg;
				logic [AW:0]       cnt_reg;
				logic [LEN_W-1:0]  ucnt_reg;
				logic              m_push;
				logic              u_push;
				logic              m_pop;
				logic              u_pop;
				logic              do_push;
				logic              do_pop;

				assign m_push  = take_wr & sel_hit(d_sel, g);
				assign u_push  = usr_push_i & sel_hit(usr_fifo_i, g) & ~m_push;
				assign m_pop   = take_rd & sel_hit(d_sel, g);
				assign u_pop   = usr_pop_i & sel_hit(usr_fifo_i, g) & ~m_pop;
				assign do_push = (m_push | u_push) & ~full_w[g];
				assign do_pop  = (m_pop | u_pop) & ~empty_w[g];

				always_ff @(posedge sys_clk_i) begin
					if (clk_en_i && do_push) begin
						mem[wp_reg] <= m_push ? d_data : usr_data_i;
					end
				end

				always_ff @(posedge sys_clk_i or posedge rst_i) begin
					if (rst_i) begin
						wp_reg  <= '0;
						rp_reg  <= '0;
						cnt_reg <= '0;
					end else if (clk_en_i) begin
						if (do_push) begin
							wp_reg <= wp_reg + 1'b1;
						end
						if (do_pop) begin
							rp_reg <= rp_reg + 1'b1;
						end
						if (do_push && !do_pop) begin
							cnt_reg <= cnt_reg + 1'b1;
						end else if (do_pop && !do_push) begin
							cnt_reg <= cnt_reg - 1'b1;
						end
					end
				end

				// Words written by the master and not yet committed
				always_ff @(posedge sys_clk_i or posedge rst_i) begin
					if (rst_i) begin
						ucnt_reg <= '0;
					end else if (clk_en_i) begin
						if (commit_fire && sel_hit(d_sel, g)) begin
							ucnt_reg <= '0;
						end else if (m_push && do_push) begin
							ucnt_reg <= ucnt_reg + 1'b1;
						end
					end
				end

				assign empty_w[g] = (cnt_reg == '0);
				assign full_w[g]  = (cnt_reg == FULL_CNT);
				assign head_w[g]  = mem[rp_reg];
				assign ucnt_w[g]  = ucnt_reg;
			end else begin : g_none
				assign empty_w[g] = 1'b1;
				assign full_w[g]  = 1'b1;
				assign head_w[g]  = sfm_pkg::DATA_RST;
				assign ucnt_w[g]  = '0;
			end
		end
	endgenerate

	// =========================================================
	// Packet commit
	logic             wr_ok;
	logic [LEN_W-1:0] new_len;
	logic             auto_fire;

	assign wr_ok   = take_wr & ~full_w[d_sel];
	assign new_len = ucnt_w[d_sel] + LEN_W'(wr_ok);
	// An auto commit and a packet end on one edge give a single packet
	assign auto_fire = auto_mode_i & wr_ok & (auto_commit_length_i != '0) &
		(new_len >= auto_commit_length_i);
	assign commit_fire = take_pe | auto_fire;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			commit_o      <= 1'b0;
			commit_fifo_o <= sfm_pkg::SEL_RST;
			commit_len_o  <= '0;
		end else if (clk_en_i) begin
			commit_o <= commit_fire;
			if (commit_fire) begin
				commit_fifo_o <= d_sel;
				commit_len_o  <= new_len;
			end
		end
	end

	// =========================================================
	// Link data and flags follow the live select with no strobe needed
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			link.dev_data    <= sfm_pkg::DATA_RST;
			link.flag_empty  <= 1'b1;
			link.flag_full   <= 1'b0;
		end else if (clk_en_i) begin
			link.dev_data    <= head_w[p_sel];
			link.flag_empty  <= empty_w[p_sel];
			link.flag_full   <= full_w[p_sel];
		end
	end

	// Enable touches only the drivers, never the pointers
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			link.dev_data_oe <= 1'b0;
		end else if (clk_en_i) begin
			link.dev_data_oe <= p_oe;
		end
	end

	// =========================================================
	// User side
	assign usr_ready_o    = ~full_w[usr_fifo_i] &
		~(take_wr & (d_sel == usr_fifo_i));
	assign usr_rd_valid_o = ~empty_w[usr_fifo_i] &
		~(take_rd & (d_sel == usr_fifo_i));
	assign usr_rd_data_o  = head_w[usr_fifo_i];
endmodule : sfm_dev

//--- sfm_pkg.sv
// Shared constants and types for the slave FIFO master port
package sfm_pkg;
	// =========================================================
	// Widths and sizes
	localparam int DATA_W     = 16;
	localparam int SEL_W      = 3;
	localparam int NUM_FIFO   = 4;
	localparam int FIFO_DEPTH = 16;
	localparam int LEN_W      = 16;
	localparam int SYNC_W     = 2;

	// =========================================================
	// Timing
	localparam int SYS_CLK_NS     = 50;
	localparam int T_SFA_NS       = 25;
	localparam int T_SFA_CYC      = (T_SFA_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int LINK_PERIOD_NS = 400;
	localparam int LINK_DIV       = LINK_PERIOD_NS / SYS_CLK_NS;

	// =========================================================
	// Reset values and host operations
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [SEL_W-1:0]  SEL_RST  = 3'h0;

	typedef enum logic [1:0] {
		SFM_OP_READ,
		SFM_OP_WRITE,
		SFM_OP_COMMIT
	} sfm_op_t;
endpackage : sfm_pkg

//--- sfm_if.sv
// Pin-level link between the external master and the FIFO port
`timescale 1ns/1ps
interface sfm_if #(
	parameter int DATA_W = sfm_pkg::DATA_W,
	parameter int SEL_W  = sfm_pkg::SEL_W
);
	logic              interface_clock;
	logic [SEL_W-1:0]  fifo_select;
	logic              fifo_chip_select;
	logic              fifo_read_strobe;
	logic              fifo_write_strobe;
	logic              fifo_output_enable;
	logic              packet_commit_strobe;
	logic [DATA_W-1:0] host_data;
	logic              host_data_oe;
	logic [DATA_W-1:0] dev_data;
	logic              dev_data_oe;
	logic              flag_empty;
	logic              flag_full;
	logic [DATA_W-1:0] data;

	// =========================================================
	// Bus level; an undriven bus reads as zero
	assign data = dev_data_oe ? dev_data :
		(host_data_oe ? host_data : '0);

	modport dev (
		input  interface_clock, fifo_select, fifo_chip_select,
		input  fifo_read_strobe, fifo_write_strobe, fifo_output_enable,
		input  packet_commit_strobe, data,
		output dev_data, dev_data_oe, flag_empty, flag_full
	);
	modport host (
		output interface_clock, fifo_select, fifo_chip_select,
		output fifo_read_strobe, fifo_write_strobe, fifo_output_enable,
		output packet_commit_strobe, host_data, host_data_oe,
		input  data, flag_empty, flag_full
	);
endinterface : sfm_if

//--- sfm_sync.sv
// Two-flop synchroniser for a group of levels
`timescale 1ns/1ps
module sfm_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	input  wire logic             clk_en_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_o   <= '0;
		end else if (clk_en_i) begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end
endmodule : sfm_sync

//--- sfm_host.sv
// External master end: drives the link clock and the FIFO strobes
`timescale 1ns/1ps
module sfm_host #(
	parameter int DATA_W = sfm_pkg::DATA_W,
	parameter int SEL_W  = sfm_pkg::SEL_W,
	parameter int DIV    = sfm_pkg::LINK_DIV
) (
	input  wire logic              sys_clk_i,
	input  wire logic              rst_i,
	input  wire logic              clk_en_i,
	input  wire logic              cmd_valid_i,
	output logic                   cmd_ready_o,
	input  wire sfm_pkg::sfm_op_t  cmd_op_i,
	input  wire logic [SEL_W-1:0]  cmd_fifo_i,
	input  wire logic [DATA_W-1:0] cmd_data_i,
	output logic                   rsp_valid_o,
	output logic      [DATA_W-1:0] rsp_data_o,
	output logic                   empty_o,
	output logic                   full_o,
	sfm_if.host                    link
);
	localparam int DW = $clog2(DIV);
	localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);
	localparam logic [DW-1:0] DIV_HALF = DW'(DIV / 2 - 1);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SEL,
		ST_STRB,
		ST_HOLD,
		ST_REL
	} sfm_hst_t;

	sfm_hst_t          state_reg;
	sfm_pkg::sfm_op_t  op_reg;
	logic [DW-1:0]     div_reg;
	logic              rise_tick;
	logic              fall_tick;
	logic [DATA_W+1:0] in_s;

	// =========================================================
	// Link clock divider; strobes and enables change only on falling edges
	assign rise_tick = (div_reg == DIV_LAST);
	assign fall_tick = (div_reg == DIV_HALF);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_reg              <= '0;
			link.interface_clock <= 1'b0;
		end else if (clk_en_i) begin
			div_reg <= rise_tick ? '0 : div_reg + 1'b1;
			if (rise_tick) begin
				link.interface_clock <= 1'b1;
			end else if (fall_tick) begin
				link.interface_clock <= 1'b0;
			end
		end
	end

	sfm_sync #(.WIDTH(DATA_W + 2)) u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.clk_en_i  (clk_en_i),
		// Empty goes in inverted so a cleared synchroniser reads as empty
		.async_i   ({~link.flag_empty, link.flag_full, link.data}),
		.sync_o    (in_s)
	);

	// =========================================================
	// Transfer sequence
	assign cmd_ready_o = (state_reg == ST_IDLE);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			op_reg    <= sfm_pkg::SFM_OP_READ;
		end else if (clk_en_i) begin
			unique case (state_reg)
				ST_IDLE: begin
					if (cmd_valid_i) begin
						op_reg    <= cmd_op_i;
						state_reg <= ST_SEL;
					end
				end
				ST_SEL: begin
					if (fall_tick) begin
						state_reg <= ST_STRB;
					end
				end
				ST_STRB: begin
					if (fall_tick) begin
						state_reg <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (fall_tick) begin
						state_reg <= ST_REL;
					end
				end
				ST_REL: begin
					if (fall_tick) begin
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Select and chip select lead the strobe by one to eight system cycles, up to one link period
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			link.fifo_select      <= sfm_pkg::SEL_RST;
			link.fifo_chip_select <= 1'b0;
			link.host_data        <= sfm_pkg::DATA_RST;
		end else if (clk_en_i) begin
			if (state_reg == ST_IDLE && cmd_valid_i) begin
				link.fifo_select      <= cmd_fifo_i;
				link.fifo_chip_select <= 1'b1;
				link.host_data        <= cmd_data_i;
			end else if (state_reg == ST_REL && fall_tick) begin
				link.fifo_chip_select <= 1'b0;
			end
		end
	end

	// Strobes span one link period, so exactly one link rise sees them
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			link.fifo_read_strobe     <= 1'b0;
			link.fifo_write_strobe    <= 1'b0;
			link.packet_commit_strobe <= 1'b0;
			link.fifo_output_enable   <= 1'b0;
			link.host_data_oe         <= 1'b0;
		end else if (clk_en_i && fall_tick) begin
			if (state_reg == ST_SEL) begin
				link.fifo_read_strobe     <= (op_reg == sfm_pkg::SFM_OP_READ);
				link.fifo_output_enable   <= (op_reg == sfm_pkg::SFM_OP_READ);
				link.fifo_write_strobe    <= (op_reg == sfm_pkg::SFM_OP_WRITE);
				link.host_data_oe         <= (op_reg == sfm_pkg::SFM_OP_WRITE);
				// A separate command keeps commit apart from writes
				link.packet_commit_strobe <=
					(op_reg == sfm_pkg::SFM_OP_COMMIT);
			end else if (state_reg == ST_STRB) begin
				link.fifo_read_strobe     <= 1'b0;
				link.fifo_write_strobe    <= 1'b0;
				link.packet_commit_strobe <= 1'b0;
			end else if (state_reg == ST_REL) begin
				link.fifo_output_enable   <= 1'b0;
				link.host_data_oe         <= 1'b0;
			end
		end
	end

	// =========================================================
	// Responses and flags
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rsp_valid_o <= 1'b0;
			rsp_data_o  <= sfm_pkg::DATA_RST;
			empty_o     <= 1'b1;
			full_o      <= 1'b0;
		end else if (clk_en_i) begin
			rsp_valid_o <= (state_reg == ST_REL) && fall_tick;
			// Word seen just before the edge that advances the pointer
			if (state_reg == ST_STRB && fall_tick &&
				op_reg == sfm_pkg::SFM_OP_READ) begin
				rsp_data_o <= in_s[DATA_W-1:0];
			end
			empty_o <= ~in_s[DATA_W+1];
			full_o  <= in_s[DATA_W];
		end
	end
endmodule : sfm_host

//--- sfm_link_assertions.sv
// Concurrent checks on the link between master end and device end
`timescale 1ns/1ps
module sfm_link_assertions (
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      interface_clock,
	input  wire logic [sfm_pkg::SEL_W-1:0] fifo_select,
	input  wire logic                      fifo_chip_select,
	input  wire logic                      fifo_read_strobe,
	input  wire logic                      fifo_write_strobe,
	input  wire logic                      fifo_output_enable,
	input  wire logic                      packet_commit_strobe,
	input  wire logic                      dev_data_oe,
	input  wire logic                      flag_empty,
	input  wire logic                      flag_full
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	// =========================================================
	// Master side strobes
	sel_setup_a: assert property (
		($rose(fifo_read_strobe) || $rose(fifo_write_strobe) ||
		$rose(packet_commit_strobe)) |-> $stable(fifo_select))
		else $error("select moved as a strobe rose");
	rd_cs_a: assert property (
		$rose(fifo_read_strobe) |-> fifo_chip_select)
		else $error("read strobe without chip select");
	wr_cs_a: assert property (
		$rose(fifo_write_strobe) |-> fifo_chip_select)
		else $error("write strobe without chip select");
	commit_sel_a: assert property (
		packet_commit_strobe && $past(packet_commit_strobe)
		|-> $stable(fifo_select))
		else $error("select moved during packet end");
	wr_commit_a: assert property (
		!(fifo_write_strobe && packet_commit_strobe))
		else $error("write strobe and packet end together");

	// =========================================================
	// Device side: bus drive and flags
	oe_on_a: assert property (
		$rose(fifo_output_enable) |-> ##2 !dev_data_oe ##1 dev_data_oe)
		else $error("bus drive not three cycles after enable");
	oe_off_a: assert property (
		$fell(fifo_output_enable) |-> ##2 dev_data_oe ##1 !dev_data_oe)
		else $error("bus release not three cycles after disable");
	wr_flag_a: assert property (
		$rose(interface_clock) && fifo_chip_select && fifo_write_strobe &&
		fifo_select < 3'h4 && flag_empty |-> ##[1:12] !flag_empty)
		else $error("empty flag stuck after a write");
	rd_flag_a: assert property (
		$rose(interface_clock) && fifo_chip_select && fifo_read_strobe &&
		fifo_select < 3'h4 && flag_full |-> ##[1:12] !flag_full)
		else $error("full flag stuck after a read");
	bad_sel_a: assert property (
		(fifo_select >= 3'h4) [*5] |-> flag_empty && flag_full)
		else $error("unused select not empty and full");
	good_sel_a: assert property (
		(fifo_select < 3'h4) [*5] |-> !(flag_empty && flag_full))
		else $error("valid select shows empty and full");
endmodule : sfm_link_assertions

//--- testbench.sv
// Bench joining the master end and the device end over the link
`timescale 1ns/1ps
module testbench;
	localparam int TMO_CYC = 8000;
	localparam sfm_pkg::sfm_op_t OP_RD = sfm_pkg::SFM_OP_READ;
	localparam sfm_pkg::sfm_op_t OP_WR = sfm_pkg::SFM_OP_WRITE;
	localparam sfm_pkg::sfm_op_t OP_PE = sfm_pkg::SFM_OP_COMMIT;
	logic                sys_clk_i;
	logic                rst_i;
	logic                async_mode, auto_mode, usr_push, usr_pop;
	logic [15:0]         auto_len, usr_data, cmd_data;
	logic [2:0]          usr_fifo, cmd_fifo, commit_fifo;
	logic                usr_ready, usr_rd_valid, commit, cmd_valid;
	logic [15:0]         usr_rd_data, commit_len, rsp_data;
	logic                cmd_ready, rsp_valid, empty, full;
	sfm_pkg::sfm_op_t    cmd_op;
	int                  fails, checks_done, n_commit, n_rsp, cyc;

	sfm_if link_if ();
	sfm_dev sfm_dev_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.clk_en_i(1'b1), .async_mode_i(async_mode), .auto_mode_i(auto_mode),
		.auto_commit_length_i(auto_len), .usr_fifo_i(usr_fifo),
		.usr_push_i(usr_push), .usr_data_i(usr_data),
		.usr_ready_o(usr_ready), .usr_pop_i(usr_pop),
		.usr_rd_valid_o(usr_rd_valid), .usr_rd_data_o(usr_rd_data),
		.commit_o(commit), .commit_fifo_o(commit_fifo),
		.commit_len_o(commit_len), .link(link_if));
	sfm_host sfm_host_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.clk_en_i(1'b1), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
		.cmd_op_i(cmd_op), .cmd_fifo_i(cmd_fifo), .cmd_data_i(cmd_data),
		.rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .empty_o(empty),
		.full_o(full), .link(link_if));
	sfm_link_assertions sfm_link_assertions_i (.sys_clk_i(sys_clk_i),
		.rst_i(rst_i), .interface_clock(link_if.interface_clock),
		.fifo_select(link_if.fifo_select),
		.fifo_chip_select(link_if.fifo_chip_select),
		.fifo_read_strobe(link_if.fifo_read_strobe),
		.fifo_write_strobe(link_if.fifo_write_strobe),
		.fifo_output_enable(link_if.fifo_output_enable),
		.packet_commit_strobe(link_if.packet_commit_strobe),
		.dev_data_oe(link_if.dev_data_oe), .flag_empty(link_if.flag_empty),
		.flag_full(link_if.flag_full));

	// =========================================================
	// Checking and closing
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim

	// =========================================================
	// Access tasks
	task automatic host_op(input sfm_pkg::sfm_op_t op, input logic [2:0] f,
		input logic [15:0] d);
		int n0;
		int k;
		n0 = n_rsp;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 100) begin
			@(negedge sys_clk_i);
			k++;
		end
		@(posedge sys_clk_i);
		#2;
		cmd_op = op;
		cmd_fifo = f;
		cmd_data = d;
		cmd_valid = 1'b1;
		@(posedge sys_clk_i);
		#2;
		cmd_valid = 1'b0;
		k = 0;
		// A read is over only once its answer has been counted
		do begin
			@(negedge sys_clk_i);
			k++;
		end while (k < 100 && !(cmd_ready === 1'b1 &&
			(op != sfm_pkg::SFM_OP_READ || n_rsp > n0)));
		if (k >= 100) fails++;
	endtask : host_op

	task automatic usr_xfer(input logic pop, input logic [2:0] f,
		input logic [15:0] d);
		int k;
		@(posedge sys_clk_i);
		#2;
		usr_fifo = f;
		usr_data = d;
		usr_push = !pop;
		usr_pop = pop;
		k = 0;
		@(negedge sys_clk_i);
		while ((pop ? usr_rd_valid : usr_ready) !== 1'b1 && k < 50) begin
			@(negedge sys_clk_i);
			k++;
		end
		check(pop ? "usr_rd_valid" : "usr_ready",
			{15'h0000, pop ? usr_rd_valid : usr_ready}, 16'h0001);
		if (pop) check("usr_rd_data", usr_rd_data, d);
		@(posedge sys_clk_i);
		#2;
		usr_push = 1'b0;
		usr_pop = 1'b0;
	endtask : usr_xfer

	task automatic commit_chk(input int n, input logic [2:0] f,
		input logic [15:0] len);
		int k;
		k = 0;
		while (n_commit < n && k < 60) begin
			@(negedge sys_clk_i);
			k++;
		end
		check("commit_count", 16'(n_commit), 16'(n));
		check("commit_fifo", 16'(commit_fifo), 16'(f));
		check("commit_len", commit_len, len);
	endtask : commit_chk

	// =========================================================
	// Clock, monitors, timeout
	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	// Pulses are counted mid-cycle, away from the edge that moves them
	always @(negedge sys_clk_i) begin
		if (rsp_valid === 1'b1) n_rsp++;
		if (commit === 1'b1) n_commit++;
	end
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == TMO_CYC) begin
			fails++;
			end_sim();
		end
	end

	// =========================================================
	// Scenarios
	initial begin
		{async_mode, auto_mode, usr_push, usr_pop, cmd_valid} = 5'h00;
		{auto_len, usr_data, cmd_data} = 48'h0;
		{usr_fifo, cmd_fifo} = 6'h00;
		cmd_op = sfm_pkg::SFM_OP_READ;
		rst_i = 1'b1;
		repeat (2) @(posedge sys_clk_i);
		#2;
		rst_i = 1'b0;
		// Flags must read empty, not full, four cycles after reset
		repeat (4) @(negedge sys_clk_i);
		check("empty_full", {14'h0000, empty, full}, 16'h0002);
		check("cmd_ready", {15'h0000, cmd_ready}, 16'h0001);
		for (int i = 0; i < 3; i++)
			host_op(OP_WR, 3'h1, 16'hA100 + 16'(i));
		host_op(OP_PE, 3'h1, 16'h0000);
		commit_chk(1, 3'h1, 16'h0003);
		for (int i = 0; i < 3; i++)
			usr_xfer(1'b1, 3'h1, 16'hA100 + 16'(i));
		for (int i = 0; i < 16; i++)
			usr_xfer(1'b0, 3'h2, 16'hB200 + 16'(i));
		@(negedge sys_clk_i);
		check("usr_ready", {15'h0000, usr_ready}, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			host_op(OP_RD, 3'h2, 16'h0000);
			check("rsp_data", rsp_data, 16'hB200 + 16'(i));
		end
		check("empty_full", {14'h0000, empty, full}, 16'h0000);
		host_op(OP_RD, 3'h5, 16'h0000);
		check("empty_full", {14'h0000, empty, full}, 16'h0003);
		host_op(OP_RD, 3'h3, 16'h0000);
		check("empty_full", {14'h0000, empty, full}, 16'h0002);
		@(posedge sys_clk_i);
		#2;
		auto_mode = 1'b1;
		auto_len = 16'h0002;
		for (int i = 0; i < 4; i++) begin
			host_op(OP_WR, 3'h0, 16'hC000 + 16'(i));
			if (i % 2 == 1) commit_chk(2 + i / 2, 3'h0, 16'h0002);
		end
		host_op(OP_WR, 3'h0, 16'hC0FF);
		host_op(OP_PE, 3'h0, 16'h0000);
		commit_chk(4, 3'h0, 16'h0001);
		for (int i = 0; i < 4; i++)
			usr_xfer(1'b1, 3'h0, 16'hC000 + 16'(i));
		usr_xfer(1'b1, 3'h0, 16'hC0FF);
		@(posedge sys_clk_i);
		#2;
		auto_mode = 1'b0;
		async_mode = 1'b1;
		host_op(OP_WR, 3'h3, 16'hD300);
		host_op(OP_WR, 3'h3, 16'hD301);
		host_op(OP_PE, 3'h3, 16'h0000);
		commit_chk(5, 3'h3, 16'h0002);
		host_op(OP_RD, 3'h3, 16'h0000);
		check("rsp_data", rsp_data, 16'hD300);
		usr_xfer(1'b1, 3'h3, 16'hD301);
		@(negedge sys_clk_i);
		check("usr_rd_valid", {15'h0000, usr_rd_valid}, 16'h0000);
		end_sim();
	end
endmodule : testbench
